// File: hw/rmfc_filter.sv
`timescale 1ns/1ps
// Level filter: a new level must persist PERIODS ticks
module rmfc_filter #(
   parameter int unsigned W = 3,
   parameter int unsigned PERIODS = rmfc_pkg::FILT_PERIODS,
   parameter logic [W-1:0] RST_VAL = '1
) (
   input wire logic clk_sys,
   input wire logic rst,
   rmfc_filt_if.filt_side f
);
   typedef struct packed {
      logic [W-1:0] filt;
      logic [W-1:0][2:0] cnt;
   } rmfc_filt_st_t;

   rmfc_filt_st_t st_q;
   rmfc_filt_st_t st_d;

   // Per-bit persistence counters, restart on any bounce
   always_comb begin
      st_d = st_q;
      for (int i = 0; i < W; i++) begin
         if (f.raw[i] == st_q.filt[i]) begin
            st_d.cnt[i] = 3'h0;
         end else if (f.tick) begin
            if (st_q.cnt[i] == 3'(PERIODS - 1)) begin
               st_d.filt[i] = f.raw[i];
               st_d.cnt[i] = 3'h0;
            end else begin
               st_d.cnt[i] = st_q.cnt[i] + 3'h1;
            end
         end
      end
   end

   // State register
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         st_q.filt <= RST_VAL;
         st_q.cnt <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign f.filt = st_q.filt;
endmodule

// File: hw/rmfc_sync.sv
`timescale 1ns/1ps
// Two-stage synchroniser for asynchronous levels
module rmfc_sync #(
   parameter int unsigned W = 1
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } rmfc_sync_st_t;

   rmfc_sync_st_t st_q;
   rmfc_sync_st_t st_d;

   // Shift chain; only stage two reads stage one
   always_comb begin
      st_d.s1 = d;
      st_d.s2 = st_q.s1;
   end

   // State register
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign q = st_q.s2;
endmodule

// File: hw/rmfc_top.sv
// Decided for this implementation: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps

// Contract
// - stop low, no force, sleep high: diode emulation
// - low-side on until its current reverses
// - diode emulation drops into discontinuous conduction
// - stop low, force high: enhanced mode, window +33%
// - all other input combinations: forced continuous
// - mode inputs filtered over seven switching periods
// - sleep input low fast slew, high slow
// - overcurrent beyond 120us trips, tri-states, latches
// - twice overcurrent trips within 2us
// - undervoltage beyond 1ms trips and tri-states
// - overvoltage beyond 1ms trips and tri-states
// - latch cleared by enable toggle or supply loss
// - above 1.7V discharge via low side to 0.85V
// - renewed excursion above 1.7V repeats discharge
// - way-overvoltage latch cleared by supply only
// - way-overvoltage detector always active
// - thermistor low pulls throttle output low only
module rmfc_top #(
   parameter int unsigned OC_CYCLES = rmfc_pkg::OC_CYC,
   parameter int unsigned UVOV_CYCLES = rmfc_pkg::UVOV_CYC
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic deep_stop_n,
   input wire logic force_diode_emulation,
   input wire logic deeper_sleep_vr,
   input wire logic regulator_on,
   input wire logic supply_ok,
   input wire logic sw_period,
   input wire logic pwm_request,
   input wire logic ls_current_reverse,
   input wire logic droop_over_oc,
   input wire logic droop_over_woc,
   input wire logic out_under_uv,
   input wire logic out_over_ov,
   input wire logic out_over_wov,
   input wire logic out_under_disch,
   input wire logic thermistor_low,
   output logic high_side_gate_o,
   output logic high_side_gate_oe,
   output logic low_side_gate_o,
   output logic low_side_gate_oe,
   output logic power_good_out,
   output logic thermal_throttle_n,
   output logic fast_slew_sel,
   output logic window_boost,
   output logic [1:0] conduction_mode,
   output logic irq,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   localparam int unsigned CW = rmfc_pkg::CNT_W;
   localparam int unsigned EW = rmfc_pkg::EV_W;

   typedef struct packed {
      logic sw_prev;
      logic reg_on_prev;
      rmfc_pkg::rmfc_mode_t mode;
      logic rev_seen;
      logic discontinuous_conduction_mode;
      logic [CW-1:0] oc_cnt;
      logic [CW-1:0] woc_cnt;
      logic [CW-1:0] uv_cnt;
      logic [CW-1:0] ov_cnt;
      logic flt;
      rmfc_pkg::rmfc_wov_t wov_st;
      logic wov_lat;
      logic hs;
      logic hs_oe;
      logic ls;
      logic ls_oe;
      logic pg;
      logic tt_n;
      logic fast;
      logic boost;
      logic irq;
      logic [7:0] ctrl;
      logic [EW-1:0] ist;
      logic [EW-1:0] imask;
      logic aw_held;
      logic w_held;
      logic [7:0] awaddr;
      logic [7:0] wdata;
      logic wstb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
   } rmfc_top_st_t;

   rmfc_top_st_t st_q;
   rmfc_top_st_t st_d;
   rmfc_pkg::rmfc_pins_t pins_raw;
   rmfc_pkg::rmfc_pins_t pins;

   rmfc_filt_if #(.W(3)) filt_if ();

   // Duration counter: runs while the condition holds, saturates
   function automatic logic [CW-1:0] run_cnt(
      input logic [CW-1:0] c,
      input logic cond,
      input logic [CW-1:0] lim
   );
      if (!cond) begin
         run_cnt = '0;
      end else if (c == lim) begin
         run_cnt = c;
      end else begin
         run_cnt = c + 17'h00001;
      end
   endfunction

   // Gather asynchronous pin levels
   always_comb begin
      pins_raw.deep_stop_n = deep_stop_n;
      pins_raw.force_diode_emulation = force_diode_emulation;
      pins_raw.deeper_sleep_vr = deeper_sleep_vr;
      pins_raw.regulator_on = regulator_on;
      pins_raw.supply_ok = supply_ok;
      pins_raw.sw_period = sw_period;
      pins_raw.pwm_request = pwm_request;
      pins_raw.ls_current_reverse = ls_current_reverse;
      pins_raw.droop_over_oc = droop_over_oc;
      pins_raw.droop_over_woc = droop_over_woc;
      pins_raw.out_under_uv = out_under_uv;
      pins_raw.out_over_ov = out_over_ov;
      pins_raw.out_over_wov = out_over_wov;
      pins_raw.out_under_disch = out_under_disch;
      pins_raw.thermistor_low = thermistor_low;
   end

   rmfc_sync #(
      .W($bits(rmfc_pkg::rmfc_pins_t))
   ) u_sync (
      .clk_sys(clk_sys),
      .rst(rst),
      .d(pins_raw),
      .q(pins)
   );

   assign filt_if.raw = {pins.deep_stop_n, pins.force_diode_emulation,
                         pins.deeper_sleep_vr};
   assign filt_if.tick = pins.sw_period & ~st_q.sw_prev;

   rmfc_filter #(
      .W(3),
      .PERIODS(rmfc_pkg::FILT_PERIODS),
      .RST_VAL(3'h4)
   ) u_filter (
      .clk_sys(clk_sys),
      .rst(rst),
      .f(filt_if)
   );

   // Next-state logic
   always_comb begin
      logic stop_n;
      logic fde;
      logic sleep;
      logic tick;
      logic toggle;
      logic clr_flt;
      logic diode;
      logic trip;
      logic halt;
      logic [EW-1:0] ev;
      stop_n = filt_if.filt[2];
      fde = filt_if.filt[1];
      sleep = filt_if.filt[0];
      tick = filt_if.tick;
      toggle = pins.regulator_on ^ st_q.reg_on_prev;
      clr_flt = 1'h0;
      diode = 1'h0;
      trip = 1'h0;
      halt = 1'h0;
      ev = '0;
      st_d = st_q;
      st_d.sw_prev = pins.sw_period;
      st_d.reg_on_prev = pins.regulator_on;

      st_d.mode = rmfc_pkg::MODE_CCM;
      if (!st_q.ctrl[rmfc_pkg::CTRL_DEM_INHIBIT] && !stop_n) begin
         if (fde) begin
            st_d.mode = rmfc_pkg::MODE_ENHANCED_DIODE_EMULATION_MODE;
         end else if (sleep) begin
            st_d.mode = rmfc_pkg::MODE_DEM;
         end
      end
      ev[rmfc_pkg::EV_MODE] = (st_d.mode != st_q.mode);
      diode = (st_q.mode != rmfc_pkg::MODE_CCM);
      st_d.boost = (st_d.mode == rmfc_pkg::MODE_ENHANCED_DIODE_EMULATION_MODE);

      // discontinuous when current reverses in a period
      st_d.rev_seen = st_q.rev_seen | pins.ls_current_reverse;
      if (tick) begin
         st_d.discontinuous_conduction_mode = diode & (st_q.rev_seen | pins.ls_current_reverse);
         st_d.rev_seen = 1'h0;
      end

      st_d.fast = ~pins.deeper_sleep_vr;

      st_d.oc_cnt = run_cnt(st_q.oc_cnt, pins.droop_over_oc,
                            CW'(OC_CYCLES));
      st_d.woc_cnt = run_cnt(st_q.woc_cnt, pins.droop_over_woc,
                             CW'(rmfc_pkg::WOC_CYC));
      st_d.uv_cnt = run_cnt(st_q.uv_cnt, pins.out_under_uv,
                            CW'(UVOV_CYCLES));
      st_d.ov_cnt = run_cnt(st_q.ov_cnt, pins.out_over_ov,
                            CW'(UVOV_CYCLES));
      ev[rmfc_pkg::EV_OC] = (st_d.oc_cnt == CW'(OC_CYCLES)) &&
                            (st_q.oc_cnt != CW'(OC_CYCLES));
      ev[rmfc_pkg::EV_WOC] = (st_d.woc_cnt == CW'(rmfc_pkg::WOC_CYC)) &&
                             (st_q.woc_cnt != CW'(rmfc_pkg::WOC_CYC));
      ev[rmfc_pkg::EV_UV] = (st_d.uv_cnt == CW'(UVOV_CYCLES)) &&
                            (st_q.uv_cnt != CW'(UVOV_CYCLES));
      ev[rmfc_pkg::EV_OV] = (st_d.ov_cnt == CW'(UVOV_CYCLES)) &&
                            (st_q.ov_cnt != CW'(UVOV_CYCLES));
      trip = (st_d.oc_cnt == CW'(OC_CYCLES)) ||
             (st_d.woc_cnt == CW'(rmfc_pkg::WOC_CYC)) ||
             (st_d.uv_cnt == CW'(UVOV_CYCLES)) ||
             (st_d.ov_cnt == CW'(UVOV_CYCLES));

      // latch clear by toggle or supply loss, set wins
      clr_flt = toggle | ~pins.supply_ok;
      st_d.flt = trip | (st_q.flt & ~clr_flt);

      case (st_q.wov_st)
         rmfc_pkg::WOV_IDLE: begin
            if (pins.out_over_wov) begin
               st_d.wov_st = rmfc_pkg::WOV_DISCH;
               ev[rmfc_pkg::EV_WOV] = 1'h1;
            end
         end
         rmfc_pkg::WOV_DISCH: begin
            if (pins.out_under_disch && !pins.out_over_wov) begin
               st_d.wov_st = rmfc_pkg::WOV_OFF;
            end
         end
         rmfc_pkg::WOV_OFF: begin
            if (pins.out_over_wov) begin
               st_d.wov_st = rmfc_pkg::WOV_DISCH;
               ev[rmfc_pkg::EV_WOV] = 1'h1;
            end
         end
         default: begin
            st_d.wov_st = rmfc_pkg::WOV_IDLE;
         end
      endcase
      st_d.wov_lat = st_q.wov_lat | (st_d.wov_st != rmfc_pkg::WOV_IDLE);
      // supply recycle is the only way out
      if (!pins.supply_ok && !pins.out_over_wov) begin
         st_d.wov_st = rmfc_pkg::WOV_IDLE;
         st_d.wov_lat = 1'h0;
      end

      // Gate drive; tri-state on any latched fault, except low side on during way-overvoltage discharge
      halt = ~pins.regulator_on | ~pins.supply_ok | st_d.flt |
             st_d.wov_lat;
      if (st_d.wov_st == rmfc_pkg::WOV_DISCH) begin
         // low side on, high side off
         st_d.hs = 1'h0;
         st_d.hs_oe = 1'h1;
         st_d.ls = 1'h1;
         st_d.ls_oe = 1'h1;
      end else if (halt) begin
         st_d.hs = 1'h0;
         st_d.hs_oe = 1'h0;
         st_d.ls = 1'h0;
         st_d.ls_oe = 1'h0;
      end else begin
         st_d.hs = pins.pwm_request;
         st_d.hs_oe = 1'h1;
         // low side off once its current reverses, in diode emulation modes only
         st_d.ls = ~pins.pwm_request & ~(diode & pins.ls_current_reverse);
         st_d.ls_oe = 1'h1;
      end
      // power good held low by either latch
      st_d.pg = ~halt;

      st_d.tt_n = ~pins.thermistor_low;
      ev[rmfc_pkg::EV_OT] = pins.thermistor_low & st_q.tt_n;

      // Write address and data taken in either order
      if (s_axi_awvalid && st_q.awready) begin
         st_d.aw_held = 1'h1;
         st_d.awaddr = s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid && st_q.wready) begin
         st_d.w_held = 1'h1;
         st_d.wdata = s_axi_wdata[7:0];
         st_d.wstb = s_axi_wstrb[0];
      end
      if (st_q.bvalid && s_axi_bready) begin
         st_d.bvalid = 1'h0;
      end

      // Register write once both halves are held
      if (st_q.aw_held && st_q.w_held && !st_q.bvalid) begin
         st_d.aw_held = 1'h0;
         st_d.w_held = 1'h0;
         st_d.bvalid = 1'h1;
         st_d.bresp = rmfc_pkg::RESP_OKAY;
         case (st_q.awaddr)
            rmfc_pkg::OFS_CTRL: begin
               if (st_q.wstb) begin
                  st_d.ctrl = st_q.wdata & 8'h01;
               end
            end
            rmfc_pkg::OFS_STATUS: begin
            end
            rmfc_pkg::OFS_INT_STAT: begin
               if (st_q.wstb) begin
                  st_d.ist = st_q.ist & ~st_q.wdata[EW-1:0];
               end
            end
            rmfc_pkg::OFS_INT_MASK: begin
               if (st_q.wstb) begin
                  st_d.imask = st_q.wdata[EW-1:0];
               end
            end
            default: begin
               st_d.bresp = rmfc_pkg::RESP_SLVERR;
            end
         endcase
      end
      // Events set after the clear so that a set wins
      st_d.ist = st_d.ist | ev;
      st_d.irq = |(st_d.ist & st_d.imask);
      st_d.awready = ~st_d.aw_held;
      st_d.wready = ~st_d.w_held;

      // Read channel
      if (st_q.rvalid && s_axi_rready) begin
         st_d.rvalid = 1'h0;
      end
      if (s_axi_arvalid && st_q.arready) begin
         st_d.rvalid = 1'h1;
         st_d.rresp = rmfc_pkg::RESP_OKAY;
         st_d.rdata = 32'h00000000;
         case (s_axi_araddr[7:0])
            rmfc_pkg::OFS_CTRL: begin
               st_d.rdata[7:0] = st_q.ctrl;
            end
            rmfc_pkg::OFS_STATUS: begin
               st_d.rdata[rmfc_pkg::ST_MODE_LO +: 2] = st_q.mode;
               st_d.rdata[rmfc_pkg::ST_FAULT] = st_q.flt;
               st_d.rdata[rmfc_pkg::ST_WOV] = st_q.wov_lat;
               st_d.rdata[rmfc_pkg::ST_POWER_GOOD_OUT] = st_q.pg;
               st_d.rdata[rmfc_pkg::ST_THROTTLE] = ~st_q.tt_n;
               st_d.rdata[rmfc_pkg::ST_FAST_SLEW] = st_q.fast;
               st_d.rdata[rmfc_pkg::ST_DCM] = st_q.discontinuous_conduction_mode;
            end
            rmfc_pkg::OFS_INT_STAT: begin
               st_d.rdata[EW-1:0] = st_q.ist;
            end
            rmfc_pkg::OFS_INT_MASK: begin
               st_d.rdata[EW-1:0] = st_q.imask;
            end
            default: begin
               st_d.rresp = rmfc_pkg::RESP_SLVERR;
            end
         endcase
      end
      st_d.arready = ~st_d.rvalid;
   end

   // State register
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         st_q <= '0;
         st_q.mode <= rmfc_pkg::MODE_CCM;
         st_q.wov_st <= rmfc_pkg::WOV_IDLE;
         st_q.tt_n <= 1'h1;
         st_q.ctrl <= rmfc_pkg::CTRL_RST;
         st_q.imask <= rmfc_pkg::MASK_RST;
      end else begin
         st_q <= st_d;
      end
   end

   // Outputs straight from the state register
   assign high_side_gate_o = st_q.hs;
   assign high_side_gate_oe = st_q.hs_oe;
   assign low_side_gate_o = st_q.ls;
   assign low_side_gate_oe = st_q.ls_oe;
   assign power_good_out = st_q.pg;
   assign thermal_throttle_n = st_q.tt_n;
   assign fast_slew_sel = st_q.fast;
   assign window_boost = st_q.boost;
   assign conduction_mode = st_q.mode;
   assign irq = st_q.irq;
   assign s_axi_awready = st_q.awready;
   assign s_axi_wready = st_q.wready;
   assign s_axi_bvalid = st_q.bvalid;
   assign s_axi_bresp = st_q.bresp;
   assign s_axi_arready = st_q.arready;
   assign s_axi_rvalid = st_q.rvalid;
   assign s_axi_rresp = st_q.rresp;
   assign s_axi_rdata = st_q.rdata;
endmodule

// File: inc/rmfc_filt_if.sv
`timescale 1ns/1ps
// Mode input glitch filter connection
interface rmfc_filt_if #(
   parameter int unsigned W = 3
);
   logic [W-1:0] raw;
   logic tick;
   logic [W-1:0] filt;
   modport filt_side (input raw, input tick, output filt);
   modport user_side (output raw, output tick, input filt);
endinterface

// File: inc/rmfc_pkg.sv
package rmfc_pkg;

   // System clock rate
   localparam int unsigned CLK_MHZ = 100;

   // Fault qualifying times, as specified
   localparam int unsigned OC_TIME_US = 120;
   localparam int unsigned WOC_TIME_NS = 2000;
   localparam int unsigned UVOV_TIME_US = 1000;

   // Cycle counts; the upper bound absorbs the input sync latency
   localparam int unsigned SYNC_CYC = 3;
   localparam int unsigned OC_CYC = OC_TIME_US * CLK_MHZ;
   localparam int unsigned WOC_CYC = (WOC_TIME_NS * CLK_MHZ) / 1000 - SYNC_CYC;
   localparam int unsigned UVOV_CYC = UVOV_TIME_US * CLK_MHZ;
   localparam int unsigned CNT_W = 17;

   // Mode glitch filter length in switching periods
   localparam int unsigned FILT_PERIODS = 7;

   // Ripple window enlargement in enhanced mode, percent
   localparam int unsigned WINDOW_BOOST_PCT = 33;

   // Register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_INT_STAT = 8'h08;
   localparam logic [7:0] OFS_INT_MASK = 8'h0C;

   // Control fields and reset values
   localparam int unsigned CTRL_DEM_INHIBIT = 0;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [6:0] MASK_RST = 7'h00;

   // Status fields
   localparam int unsigned ST_MODE_LO = 0;
   localparam int unsigned ST_FAULT = 2;
   localparam int unsigned ST_WOV = 3;
   localparam int unsigned ST_POWER_GOOD_OUT = 4;
   localparam int unsigned ST_THROTTLE = 5;
   localparam int unsigned ST_FAST_SLEW = 6;
   localparam int unsigned ST_DCM = 7;

   // Interrupt event bits
   localparam int unsigned EV_OC = 0;
   localparam int unsigned EV_WOC = 1;
   localparam int unsigned EV_UV = 2;
   localparam int unsigned EV_OV = 3;
   localparam int unsigned EV_WOV = 4;
   localparam int unsigned EV_OT = 5;
   localparam int unsigned EV_MODE = 6;
   localparam int unsigned EV_W = 7;

   // Bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {MODE_CCM, MODE_DEM, MODE_ENHANCED_DIODE_EMULATION_MODE} rmfc_mode_t;
   typedef enum logic [1:0] {WOV_IDLE, WOV_DISCH, WOV_OFF} rmfc_wov_t;

   // Pin levels that cross into the clock domain
   typedef struct packed {
      logic deep_stop_n;
      logic force_diode_emulation;
      logic deeper_sleep_vr;
      logic regulator_on;
      logic supply_ok;
      logic sw_period;
      logic pwm_request;
      logic ls_current_reverse;
      logic droop_over_oc;
      logic droop_over_woc;
      logic out_under_uv;
      logic out_over_ov;
      logic out_over_wov;
      logic out_under_disch;
      logic thermistor_low;
   } rmfc_pins_t;

endpackage

// File: sim/regulator_mode_and_fault_control_bench.sv
`timescale 1ns/1ps
module regulator_mode_and_fault_control_bench;
   logic clk_sys = 1'h0, rst = 1'h1, on = 1'h1, ok = 1'h1;
   logic [2:0] want = 3'h4;
   logic [3:0] flt = 4'h0;
   logic way_overvoltage = 1'h0, disch = 1'h0, hot = 1'h0, pwm = 1'h1, rev = 1'h0;
   logic dsn, fde, slp, ron, sok, swp, hs_o, hs_oe, ls_o, ls_oe;
   logic pg, tt_n, fast, boost, irq, awr, wr_rdy, bv, arr, rv;
   logic [1:0] mode, bresp, rresp, resp;
   logic [31:0] awa = '0, wd = '0, ara = '0, rdata, rdv;
   logic awv = 1'h0, wv = 1'h0, brdy = 1'h0, arv = 1'h0, rrdy = 1'h0;
   int mismatches = 0, n_tests = 0, cycles = 0;
   always #5 clk_sys = ~clk_sys;
   rmfc_host_model i_host (.clk_sys(clk_sys), .want_on(on), .want_ok(ok),
      .want_mode(want), .deep_stop_n(dsn), .force_diode_emulation(fde),
      .deeper_sleep_vr(slp), .regulator_on(ron), .supply_ok(sok),
      .sw_period(swp));
   rmfc_top #(.OC_CYCLES(20), .UVOV_CYCLES(30)) i_dut (.clk_sys(clk_sys),
      .rst(rst), .deep_stop_n(dsn), .force_diode_emulation(fde),
      .deeper_sleep_vr(slp), .regulator_on(ron), .supply_ok(sok),
      .sw_period(swp), .pwm_request(pwm), .ls_current_reverse(rev),
      .droop_over_oc(flt[0]), .droop_over_woc(flt[1]),
      .out_under_uv(flt[2]), .out_over_ov(flt[3]), .out_over_wov(way_overvoltage),
      .out_under_disch(disch), .thermistor_low(hot),
      .high_side_gate_o(hs_o), .high_side_gate_oe(hs_oe),
      .low_side_gate_o(ls_o), .low_side_gate_oe(ls_oe),
      .power_good_out(pg), .thermal_throttle_n(tt_n), .fast_slew_sel(fast),
      .window_boost(boost), .conduction_mode(mode), .irq(irq),
      .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
      .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
      .s_axi_wready(wr_rdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
      .s_axi_bready(brdy), .s_axi_araddr(ara), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rv), .s_axi_rready(rrdy));
   task automatic cyc(int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         mismatches++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Bus write, both channels offered together
   task automatic wr(logic [7:0] a, logic [31:0] d);
      @(posedge clk_sys);
      {awa, wd, awv, wv, brdy} <= {24'h0, a, d, 3'h7};
      do begin
         @(posedge clk_sys);
         if (awr) awv <= 1'h0;
         if (wr_rdy) wv <= 1'h0;
      end while (bv !== 1'h1);
      resp = bresp;
      brdy <= 1'h0;
   endtask
   task automatic rd(logic [7:0] a);
      @(posedge clk_sys);
      {ara, arv, rrdy} <= {24'h0, a, 2'h3};
      do begin
         @(posedge clk_sys);
         if (arr) arv <= 1'h0;
      end while (rv !== 1'h1);
      {rdv, resp} = {rdata, rresp};
      rrdy <= 1'h0;
   endtask
   function automatic logic [1:0] exp_mode(logic [2:0] m);
      if (!m[2] && m[1]) return 2'h2;
      return (m == 3'h1) ? 2'h1 : 2'h0;
   endfunction
   task automatic t_regs;
      rd(8'h0C);
      chk("mask reset", 32'h0, rdv);
      rd(8'h10);
      chk("rd err", 32'h2, resp);
      wr(8'h14, 32'h1);
      chk("wr err", 32'h2, resp);
      rd(8'h04);
      chk("power_good_out", 32'h10, rdv & 32'h10);
      $display("test regs done");
   endtask
   task automatic t_modes;
      for (int m = 0; m < 8; m++) begin
         want <= m[2:0];
         cyc(100);
         chk("mode", exp_mode(m[2:0]), mode);
         chk("boost", exp_mode(m[2:0]) == 2'h2, boost);
         chk("fast slew", !m[0], fast);
      end
      want <= 3'h1;
      cyc(50);
      chk("glitch", 32'h0, mode);
      cyc(50);
      pwm <= 1'h0;
      cyc(6);
      chk("ls on", 32'h1, ls_o);
      rev <= 1'h1;
      cyc(25);
      chk("ls off", 32'h0, ls_o);
      rd(8'h04);
      chk("dcm", 32'h81, rdv & 32'h83);
      {pwm, rev} <= 2'h2;
      want <= 3'h4;
      cyc(100);
      wr(8'h08, 32'h7F);
      $display("test modes done");
   endtask
   task automatic t_fault(int k);
      int lo[4] = '{10, 1, 20, 20};
      int hi[4] = '{40, 210, 50, 50};
      flt[k] <= 1'h1;
      cyc(lo[k]);
      chk("early", 32'h1, pg);
      cyc(hi[k]);
      chk("tripped", 32'h0, {hs_oe, ls_oe, pg});
      flt[k] <= 1'h0;
      wr(8'h0C, 32'h1 << k);
      cyc(3);
      chk("irq", 32'h1, irq);
      rd(8'h08);
      chk("event", 32'h1 << k, rdv & 32'hF);
      wr(8'h08, 32'h7F);
      cyc(3);
      chk("irq clr", 32'h0, {irq, pg});
      if (k == 1) ok <= 1'h0;
      else on <= 1'h0;
      cyc(10);
      {on, ok} <= 2'h3;
      cyc(10);
      chk("recovered", 32'h1, pg);
      wr(8'h0C, 32'h0);
      $display("test fault %0d done", k);
   endtask
   task automatic t_wov;
      flt[0] <= 1'h1;
      cyc(40);
      {flt[0], way_overvoltage} <= 2'h1;
      cyc(6);
      chk("discharge", 32'hC, {ls_oe, ls_o, hs_o, pg});
      on <= 1'h0;
      cyc(10);
      on <= 1'h1;
      cyc(10);
      chk("toggle", 32'hC, {ls_oe, ls_o, hs_o, pg});
      {way_overvoltage, disch} <= 2'h1;
      cyc(6);
      chk("all off", 32'h0, {hs_oe, ls_oe, pg});
      {way_overvoltage, disch} <= 2'h2;
      cyc(6);
      chk("repeat", 32'hC, {ls_oe, ls_o, hs_o, pg});
      rd(8'h08);
      chk("wov event", 32'h10, rdv & 32'h10);
      {way_overvoltage, disch, ok} <= 3'h2;
      cyc(10);
      {disch, ok} <= 2'h1;
      cyc(10);
      chk("supply", 32'h1, pg);
      wr(8'h08, 32'h7F);
      $display("test wov done");
   endtask
   task automatic t_therm;
      hot <= 1'h1;
      cyc(6);
      chk("throttle", 32'h1, {tt_n, pg});
      hot <= 1'h0;
      cyc(6);
      chk("throttle off", 32'h1, tt_n);
      $display("test thermal done");
   endtask
   task end_of_test;
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // Hang guard
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         mismatches++;
         end_of_test;
      end
   end
   initial begin
      cyc(4);
      rst <= 1'h0;
      cyc(10);
      t_regs;
      t_modes;
      for (int k = 0; k < 4; k++) t_fault(k);
      t_wov;
      t_therm;
      end_of_test;
   end
endmodule

// File: sim/rmfc_assertions.sv
`timescale 1ns/1ps
module rmfc_checker #(
   parameter int unsigned OC_CYCLES = 20
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic deeper_sleep_vr,
   input wire logic droop_over_oc,
   input wire logic droop_over_woc,
   input wire logic out_over_wov,
   input wire logic thermistor_low,
   input wire logic high_side_gate_o,
   input wire logic high_side_gate_oe,
   input wire logic low_side_gate_o,
   input wire logic low_side_gate_oe,
   input wire logic power_good_out,
   input wire logic thermal_throttle_n,
   input wire logic fast_slew_sel,
   input wire logic window_boost,
   input wire logic [1:0] conduction_mode
);
   int oc_q, woc_q;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   // Runs of high overcurrent comparator samples
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         oc_q <= 0;
         woc_q <= 0;
      end else begin
         oc_q <= droop_over_oc ? oc_q + 1 : 0;
         woc_q <= droop_over_woc ? woc_q + 1 : 0;
      end
   end
   // Trips, discharge and status levels
   a_oc_trip: assert property (oc_q == OC_CYCLES + 6 |->
      !power_good_out && !high_side_gate_oe && !low_side_gate_oe)
      else $error("no oc trip");
   a_woc_trip: assert property (woc_q == rmfc_pkg::WOC_CYC + 6 |->
      !power_good_out && !high_side_gate_oe && !low_side_gate_oe)
      else $error("no woc trip");
   a_wov_disch: assert property (out_over_wov [*4] |->
      low_side_gate_oe && low_side_gate_o && !high_side_gate_o
      && !power_good_out) else $error("no discharge");
   a_tri_no_power_good_out: assert property (
      !high_side_gate_oe && !low_side_gate_oe |-> !power_good_out)
      else $error("power_good_out while off");
   a_throttle_on: assert property (
      thermistor_low [*4] |-> !thermal_throttle_n)
      else $error("no throttle");
   a_throttle_off: assert property (
      !thermistor_low [*4] |-> thermal_throttle_n)
      else $error("throttle stuck");
   a_slew_fast: assert property ($fell(deeper_sleep_vr) ##1
      !deeper_sleep_vr [*3] |-> fast_slew_sel)
      else $error("no fast slew");
   a_slew_slow: assert property (
      deeper_sleep_vr [*4] |-> !fast_slew_sel)
      else $error("no slow slew");
   a_boost_mode: assert property (
      window_boost |-> conduction_mode == 2'h2)
      else $error("boost outside enhanced");
endmodule
bind rmfc_top rmfc_checker #(.OC_CYCLES(OC_CYCLES)) i_chk (.*);

// File: sim/rmfc_host_model.sv
`timescale 1ns/1ps
module rmfc_host_model #(
   parameter int unsigned HALF = 5
) (
   input wire logic clk_sys,
   input wire logic want_on,
   input wire logic want_ok,
   input wire logic [2:0] want_mode,
   output logic deep_stop_n,
   output logic force_diode_emulation,
   output logic deeper_sleep_vr,
   output logic regulator_on,
   output logic supply_ok,
   output logic sw_period
);
   int cnt;
   // Power-up levels
   initial begin
      cnt = 0;
      sw_period = 1'h0;
      {deep_stop_n, force_diode_emulation, deeper_sleep_vr} = 3'h4;
      {regulator_on, supply_ok} = 2'h3;
   end
   // Switching ticks and system levels
   always @(posedge clk_sys) begin
      cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
      if (cnt == HALF - 1) sw_period <= ~sw_period;
      {deep_stop_n, force_diode_emulation, deeper_sleep_vr} <= want_mode;
      {regulator_on, supply_ok} <= {want_on, want_ok};
   end
endmodule
